/* hdl/uart_port_pkg.sv */
package uart_port_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_DIV    = 8'h04;
	localparam logic [7:0] OFS_TXDATA = 8'h08;
	localparam logic [7:0] OFS_RXDATA = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RTSLVL = 8'h14;
	// control register fields
	localparam int CTRL_TX_EN    = 0;
	localparam int CTRL_RX_EN    = 1;
	localparam int CTRL_LOOP     = 2;
	localparam int CTRL_PDOWN    = 3;
	localparam int CTRL_RTS_AUTO = 4;
	localparam int CTRL_RTS_SW   = 5;
	localparam int CTRL_CTS_EN   = 6;
	localparam int CTRL_W        = 7;
	// status register fields
	localparam int ST_HOLD_FULL = 0;
	localparam int ST_TX_BUSY   = 1;
	localparam int ST_RX_AVAIL  = 2;
	localparam int ST_RX_FULL   = 3;
	localparam int ST_OVERRUN   = 4;
	localparam int ST_FRAME_ERR = 5;
	localparam int ST_CLK_RUN   = 6;
	localparam int ST_CTS       = 7;
	localparam int ST_RTS       = 8;
	localparam int ST_COUNT_LSB = 16;
	// reset values
	localparam logic [6:0]  CTRL_RST   = 7'h00;
	localparam logic [15:0] DIV_RST    = 16'h000A;
	localparam logic [7:0]  RTSLVL_RST = 8'h0C;
	// framing: 16 serial clocks per bit, sample start at its middle
	localparam logic [3:0] SUB_LAST = 4'hF;
	localparam logic [3:0] SUB_MID  = 4'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int DATA_BITS  = 8;
	localparam int RXQ_DEPTH  = 16;
	typedef enum logic [1:0] {FR_IDLE, FR_START, FR_DATA, FR_STOP} frame_state_t;
endpackage : uart_port_pkg

/* hdl/serial_clk_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_clk_gen (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        run_i,      // low stops the serial clock
	input  wire logic [15:0] half_i,     // half period minus one, in clock cycles
	output logic             rise_o,     // one-cycle pulse at serial clock rise
	output logic             fall_o      // one-cycle pulse at serial clock fall
);
	logic [15:0] cnt_r;   // half period counter
	logic        sclk_r;  // serial clock level
	wire         wrap = (cnt_r >= half_i);

	// stopped clock restarts from a low level so the first edge is a rise
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r  <= 16'h0000;
			sclk_r <= 1'b0;
			rise_o <= 1'b0;
			fall_o <= 1'b0;
		end else if (!run_i) begin
			cnt_r  <= 16'h0000;
			sclk_r <= 1'b0;
			rise_o <= 1'b0;
			fall_o <= 1'b0;
		end else begin
			cnt_r  <= wrap ? 16'h0000 : cnt_r + 16'h0001;
			sclk_r <= wrap ? ~sclk_r : sclk_r;
			rise_o <= wrap & ~sclk_r;
			fall_o <= wrap & sclk_r;
		end
	end
endmodule : serial_clk_gen
`default_nettype wire

/* hdl/rx_queue_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_queue_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             push_i,     // ignored when full
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic             pop_i,      // ignored when empty
	output logic      [WIDTH-1:0] rd_data_o,  // head word, registered
	output logic      [AW:0]      count_o,
	output logic                  full_o,
	output logic                  empty_o
);
	logic [WIDTH-1:0] mem [DEPTH];  // storage
	logic [AW-1:0]    wp_r;         // write pointer
	logic [AW-1:0]    rp_r;         // read pointer
	logic [AW:0]      cnt_r;        // fill level
	wire              do_push = push_i & (cnt_r != DEPTH[AW:0]);
	wire              do_pop  = pop_i & (cnt_r != '0);
	wire [AW-1:0]     rp_nxt  = do_pop ? rp_r + 1'b1 : rp_r;

	assign count_o = cnt_r;
	assign full_o  = (cnt_r == DEPTH[AW:0]);
	assign empty_o = (cnt_r == '0);

	// storage has no reset
	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem[wp_r] <= wr_data_i;
		end
	end

	// head register bypasses a word written to the slot about to be read
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_r      <= '0;
			rp_r      <= '0;
			cnt_r     <= '0;
			rd_data_o <= '0;
		end else begin
			wp_r      <= do_push ? wp_r + 1'b1 : wp_r;
			rp_r      <= rp_nxt;
			cnt_r     <= cnt_r + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
			rd_data_o <= (do_push && wp_r == rp_nxt) ? wr_data_i : mem[rp_nxt];
		end
	end
endmodule : rx_queue_mem
`default_nettype wire

/* hdl/uart_port.sv */
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module uart_port #(
	parameter int RXQ_DEPTH = uart_port_pkg::RXQ_DEPTH
) (
	input  wire logic        MCLK_I,
	input  wire logic        RST_N_I,
	// bus slave
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic      [31:0] HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	// serial pins
	input  wire logic        SERIAL_RX_LINE_I,
	input  wire logic        CLEAR_TO_SEND_IN_N_I,
	output logic             SERIAL_TX_LINE_O,
	output logic             REQUEST_TO_SEND_OUT_N_O
);
	localparam int AW = $clog2(RXQ_DEPTH);
	localparam int DB = uart_port_pkg::DATA_BITS;

	// one decoder shared by read mux, writes and the pop strobe
	function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
		hit = (a[31:8] == 24'h00_0000) && (a[7:0] == ofs);
	endfunction : hit

	// bus phase tracking
	logic        dp_wr_r;    // write data phase pending
	logic [31:0] dp_addr_r;  // address of that write
	// software registers
	logic [uart_port_pkg::CTRL_W-1:0] ctrl_r;
	logic [15:0]   div_r;       // serial clock half period minus one
	logic [7:0]    rtslvl_r;    // negate request-to-send at this fill
	logic [DB-1:0] hold_r;      // transmit holding word
	logic          hold_full_r;
	logic          overrun_r;   // sticky, write one to clear
	logic          frame_err_r; // sticky, write one to clear
	// serial clock control
	logic          clk_run_r;
	logic          rx_prev_r;   // previous receive line level
	logic          rx_d_r;      // registered receive source
	wire           srise;
	wire           sfall;
	// transmitter
	uart_port_pkg::frame_state_t tx_st_r;
	logic [3:0]    tx_sub_r;
	logic [2:0]    tx_bit_r;
	logic [DB-1:0] tx_sh_r;
	logic          tx_line_r;   // internal line before loopback gating
	// receiver
	uart_port_pkg::frame_state_t rx_st_r;
	logic [3:0]    rx_sub_r;
	logic [2:0]    rx_bit_r;
	logic [DB-1:0] rx_sh_r;
	logic          rx_push;
	// queue
	logic [DB-1:0] q_head;
	logic [AW:0]   q_count;
	logic          q_full;
	logic          q_empty;

	// named control fields
	wire tx_en    = ctrl_r[uart_port_pkg::CTRL_TX_EN];
	wire rx_en    = ctrl_r[uart_port_pkg::CTRL_RX_EN];
	wire loop_en  = ctrl_r[uart_port_pkg::CTRL_LOOP];
	wire pdown    = ctrl_r[uart_port_pkg::CTRL_PDOWN];
	wire rts_auto = ctrl_r[uart_port_pkg::CTRL_RTS_AUTO];
	wire rts_sw   = ctrl_r[uart_port_pkg::CTRL_RTS_SW];
	wire cts_en   = ctrl_r[uart_port_pkg::CTRL_CTS_EN];

	// address phase decode; writes and the receive pop need word transfers, reads of any size return data
	wire ap_sel   = HSEL_I & HTRANS_I[1] & HREADY_I;
	wire ap_word  = (HSIZE_I == 3'h2);
	wire ap_rd    = ap_sel & ~HWRITE_I;
	wire ap_wr    = ap_sel & HWRITE_I & ap_word;
	wire pop_rx   = ap_rd & ap_word & hit(HADDR_I, uart_port_pkg::OFS_RXDATA) & ~q_empty;
	// data phase write strobes
	wire wr_ctrl  = dp_wr_r & hit(dp_addr_r, uart_port_pkg::OFS_CTRL);
	wire wr_div   = dp_wr_r & hit(dp_addr_r, uart_port_pkg::OFS_DIV);
	wire wr_tx    = dp_wr_r & hit(dp_addr_r, uart_port_pkg::OFS_TXDATA);
	wire wr_stat  = dp_wr_r & hit(dp_addr_r, uart_port_pkg::OFS_STATUS);
	wire wr_rtsl  = dp_wr_r & hit(dp_addr_r, uart_port_pkg::OFS_RTSLVL);

	// handshake levels
	wire cts_ok   = ~cts_en | ~CLEAR_TO_SEND_IN_N_I;
	wire rts_nxt  = rts_auto ? ({{(7-AW){1'b0}}, q_count} < rtslvl_r) : rts_sw;
	wire tx_idle  = (tx_st_r == uart_port_pkg::FR_IDLE);
	wire rx_idle  = (rx_st_r == uart_port_pkg::FR_IDLE);
	wire tx_go    = tx_idle & hold_full_r & tx_en & cts_ok;
	wire rx_edge  = SERIAL_RX_LINE_I ^ rx_prev_r;
	wire rx_src   = loop_en ? tx_line_r : SERIAL_RX_LINE_I;

	// status word
	logic [31:0] status;
	always_comb begin
		status = 32'h0000_0000;
		status[uart_port_pkg::ST_HOLD_FULL] = hold_full_r;
		status[uart_port_pkg::ST_TX_BUSY]   = ~tx_idle;
		status[uart_port_pkg::ST_RX_AVAIL]  = ~q_empty;
		status[uart_port_pkg::ST_RX_FULL]   = q_full;
		status[uart_port_pkg::ST_OVERRUN]   = overrun_r;
		status[uart_port_pkg::ST_FRAME_ERR] = frame_err_r;
		status[uart_port_pkg::ST_CLK_RUN]   = clk_run_r;
		status[uart_port_pkg::ST_CTS]       = ~CLEAR_TO_SEND_IN_N_I;
		status[uart_port_pkg::ST_RTS]       = ~REQUEST_TO_SEND_OUT_N_O;
		status[uart_port_pkg::ST_COUNT_LSB +: AW+1] = q_count;
	end

	// read mux; unmapped addresses read as zero
	logic [31:0] rd_mux;
	always_comb begin
		if (hit(HADDR_I, uart_port_pkg::OFS_CTRL)) begin
			rd_mux = {25'h000_0000, ctrl_r};
		end else if (hit(HADDR_I, uart_port_pkg::OFS_DIV)) begin
			rd_mux = {16'h0000, div_r};
		end else if (hit(HADDR_I, uart_port_pkg::OFS_RXDATA)) begin
			rd_mux = {24'h00_0000, q_head};
		end else if (hit(HADDR_I, uart_port_pkg::OFS_STATUS)) begin
			rd_mux = status;
		end else if (hit(HADDR_I, uart_port_pkg::OFS_RTSLVL)) begin
			rd_mux = {24'h00_0000, rtslvl_r};
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end

	// bus slave: zero wait states, always OKAY
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			dp_wr_r     <= 1'b0;
			dp_addr_r   <= 32'h0000_0000;
			HRDATA_O    <= 32'h0000_0000;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end else begin
			dp_wr_r     <= ap_wr;
			dp_addr_r   <= ap_wr ? HADDR_I : dp_addr_r;
			HRDATA_O    <= ap_rd ? rd_mux : HRDATA_O;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end
	end

	// plain configuration registers
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			div_r    <= uart_port_pkg::DIV_RST;
			rtslvl_r <= uart_port_pkg::RTSLVL_RST;
		end else begin
			div_r    <= wr_div ? HWDATA_I[15:0] : div_r;
			rtslvl_r <= wr_rtsl ? HWDATA_I[7:0] : rtslvl_r;
		end
	end

	// control: a receive transition clears power-down, a software write wins
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctrl_r <= uart_port_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= HWDATA_I[uart_port_pkg::CTRL_W-1:0];
		end else if (rx_edge) begin
			ctrl_r[uart_port_pkg::CTRL_PDOWN] <= 1'b0;
		end
	end

	// clock gating: stops only between frames so nothing is cut short
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			clk_run_r <= 1'b1;
			rx_prev_r <= 1'b1;
		end else begin
			rx_prev_r <= SERIAL_RX_LINE_I;
			if (rx_edge || !pdown) begin
				clk_run_r <= 1'b1;
			end else if (tx_idle && rx_idle) begin
				clk_run_r <= 1'b0;
			end
		end
	end

	serial_clk_gen u_sclk (
		.clk_i   (MCLK_I),
		.rst_n_i (RST_N_I),
		.run_i   (clk_run_r),
		.half_i  (div_r),
		.rise_o  (srise),
		.fall_o  (sfall)
	);

	// holding word: a write landing as the frame loads is dropped, holding is still full then
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			hold_r      <= '0;
			hold_full_r <= 1'b0;
		end else if (wr_tx && !hold_full_r) begin
			hold_r      <= HWDATA_I[DB-1:0];
			hold_full_r <= 1'b1;
		end else if (sfall && tx_go) begin
			hold_full_r <= 1'b0;
		end
	end

	// transmitter: every line change except the return to mark on disable happens on a serial clock fall
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			tx_st_r   <= uart_port_pkg::FR_IDLE;
			tx_sub_r  <= 4'h0;
			tx_bit_r  <= 3'h0;
			tx_sh_r   <= '0;
			tx_line_r <= 1'b1;
		end else if (!tx_en) begin
			tx_st_r   <= uart_port_pkg::FR_IDLE; // disable aborts the frame
			tx_line_r <= 1'b1;
		end else if (sfall) begin
			tx_sub_r <= tx_sub_r + 4'h1;
			case (tx_st_r)
				uart_port_pkg::FR_IDLE: begin
					tx_line_r <= 1'b1;
					if (tx_go) begin
						tx_st_r   <= uart_port_pkg::FR_START;
						tx_sh_r   <= hold_r;
						tx_sub_r  <= 4'h0;
						tx_line_r <= 1'b0;
					end
				end
				uart_port_pkg::FR_START: begin
					if (tx_sub_r == uart_port_pkg::SUB_LAST) begin
						tx_st_r   <= uart_port_pkg::FR_DATA;
						tx_bit_r  <= 3'h0;
						tx_line_r <= tx_sh_r[0];
					end
				end
				uart_port_pkg::FR_DATA: begin
					if (tx_sub_r == uart_port_pkg::SUB_LAST) begin
						if (tx_bit_r == uart_port_pkg::BIT_LAST) begin
							tx_st_r   <= uart_port_pkg::FR_STOP;
							tx_line_r <= 1'b1;
						end else begin
							tx_sh_r   <= tx_sh_r >> 1;
							tx_bit_r  <= tx_bit_r + 3'h1;
							tx_line_r <= tx_sh_r[1];
						end
					end
				end
				default: begin
					if (tx_sub_r == uart_port_pkg::SUB_LAST) begin
						tx_st_r <= uart_port_pkg::FR_IDLE;
					end
				end
			endcase
		end
	end

	// receiver: start checked mid-bit, then one sample per bit time
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rx_d_r   <= 1'b1;
			rx_st_r  <= uart_port_pkg::FR_IDLE;
			rx_sub_r <= 4'h0;
			rx_bit_r <= 3'h0;
			rx_sh_r  <= '0;
		end else begin
			rx_d_r <= rx_src;
			if (!rx_en) begin
				rx_st_r <= uart_port_pkg::FR_IDLE;
			end else if (srise) begin
				rx_sub_r <= rx_sub_r + 4'h1;
				case (rx_st_r)
					uart_port_pkg::FR_IDLE: begin
						rx_sub_r <= 4'h0;
						if (!rx_d_r) begin
							rx_st_r <= uart_port_pkg::FR_START;
						end
					end
					uart_port_pkg::FR_START: begin
						if (rx_sub_r == uart_port_pkg::SUB_MID) begin
							rx_sub_r <= 4'h0;
							rx_bit_r <= 3'h0;
							// a glitch shorter than half a bit is dropped
							rx_st_r  <= rx_d_r ? uart_port_pkg::FR_IDLE : uart_port_pkg::FR_DATA;
						end
					end
					uart_port_pkg::FR_DATA: begin
						if (rx_sub_r == uart_port_pkg::SUB_LAST) begin
							rx_sh_r  <= {rx_d_r, rx_sh_r[DB-1:1]};
							rx_bit_r <= rx_bit_r + 3'h1;
							if (rx_bit_r == uart_port_pkg::BIT_LAST) begin
								rx_st_r <= uart_port_pkg::FR_STOP;
							end
						end
					end
					default: begin
						if (rx_sub_r == uart_port_pkg::SUB_LAST) begin
							rx_st_r <= uart_port_pkg::FR_IDLE;
						end
					end
				endcase
			end
		end
	end

	// stop bit sample; a low stop bit is a framing error and is not queued
	wire stop_samp = rx_en & srise & (rx_st_r == uart_port_pkg::FR_STOP)
		& (rx_sub_r == uart_port_pkg::SUB_LAST);
	assign rx_push = stop_samp & rx_d_r;

	// sticky errors: a new event wins over a clearing write
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			overrun_r   <= 1'b0;
			frame_err_r <= 1'b0;
		end else begin
			overrun_r   <= (rx_push & q_full)
				| (overrun_r & ~(wr_stat & HWDATA_I[uart_port_pkg::ST_OVERRUN]));
			frame_err_r <= (stop_samp & ~rx_d_r)
				| (frame_err_r & ~(wr_stat & HWDATA_I[uart_port_pkg::ST_FRAME_ERR]));
		end
	end

	rx_queue_mem #(
		.WIDTH (DB),
		.DEPTH (RXQ_DEPTH)
	) u_rxq (
		.clk_i     (MCLK_I),
		.rst_n_i   (RST_N_I),
		.push_i    (rx_push),
		.wr_data_i (rx_sh_r),
		.pop_i     (pop_rx),
		.rd_data_o (q_head),
		.count_o   (q_count),
		.full_o    (q_full),
		.empty_o   (q_empty)
	);

	// pins from flops; loopback and disable keep the wire at mark
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			SERIAL_TX_LINE_O        <= 1'b1;
			REQUEST_TO_SEND_OUT_N_O <= 1'b1;
		end else begin
			SERIAL_TX_LINE_O        <= loop_en | ~tx_en | tx_line_r;
			REQUEST_TO_SEND_OUT_N_O <= ~rts_nxt;
		end
	end
endmodule : uart_port
`default_nettype wire

/* tb/uart_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_port_monitor #(
	parameter int RXQ_DEPTH = 16
) (
	input wire logic        MCLK_I,
	input wire logic        RST_N_I,
	input wire logic        HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0]  HTRANS_I,
	input wire logic        HWRITE_I,
	input wire logic [2:0]  HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic        HREADY_I,
	input wire logic [31:0] HRDATA_O,
	input wire logic        HREADYOUT_O,
	input wire logic        HRESP_O,
	input wire logic        SERIAL_RX_LINE_I,
	input wire logic        CLEAR_TO_SEND_IN_N_I,
	input wire logic        SERIAL_TX_LINE_O,
	input wire logic        REQUEST_TO_SEND_OUT_N_O
);
	// transfer accepted at this edge
	wire        take_w = HSEL_I && HTRANS_I[1] && HREADY_I;
	logic        wr_r;     // write data phase pending
	logic [7:0]  wofs_r;   // offset of that write
	logic [6:0]  ctrl_r;   // software view of control
	logic [6:0]  ctrl_d_r; // one cycle older
	logic [15:0] div_r;    // divider shadow
	logic [21:0] low_r;    // cycles tx line low so far
	// one bit is 32 clocks per divider step
	wire [21:0] bit_w = {div_r + 17'h0_0001, 5'h00};
	// shadows follow word writes only, as the slave does
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_r     <= 1'b0;
			wofs_r   <= 8'h00;
			ctrl_r   <= uart_port_pkg::CTRL_RST;
			ctrl_d_r <= uart_port_pkg::CTRL_RST;
			div_r    <= uart_port_pkg::DIV_RST;
			low_r    <= 22'h00_0000;
		end else begin
			wr_r     <= take_w && HWRITE_I && HSIZE_I == 3'h2;
			wofs_r   <= HADDR_I[7:0];
			ctrl_d_r <= ctrl_r;
			low_r    <= SERIAL_TX_LINE_O ? 22'h00_0000 : low_r + 22'h00_0001;
			// hardware wake clears power-down, so bit 3 is never trusted
			if (wr_r && wofs_r == uart_port_pkg::OFS_CTRL) begin
				ctrl_r <= HWDATA_I[6:0];
			end
			if (wr_r && wofs_r == uart_port_pkg::OFS_DIV) begin
				div_r <= HWDATA_I[15:0];
			end
		end
	end
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	// read requests by offset
	sequence rd_ctrl_s;
		take_w && !HWRITE_I && HADDR_I == 32'(uart_port_pkg::OFS_CTRL);
	endsequence
	sequence rd_div_s;
		take_w && !HWRITE_I && HADDR_I == 32'(uart_port_pkg::OFS_DIV);
	endsequence
	// control unchanged long enough for the pins to follow
	sequence ctrl_calm_s;
		ctrl_r == ctrl_d_r;
	endsequence
	ready_ok_a: assert property (HREADYOUT_O && !HRESP_O)
		else $error("bus slave stalled or flagged an error");
	reset_idle_a: assert property ($rose(RST_N_I) |-> SERIAL_TX_LINE_O && REQUEST_TO_SEND_OUT_N_O)
		else $error("pins not idle after reset");
	idle_high_a: assert property (
		ctrl_calm_s ##0 (!ctrl_r[uart_port_pkg::CTRL_TX_EN] || ctrl_r[uart_port_pkg::CTRL_LOOP]) |-> SERIAL_TX_LINE_O)
		else $error("tx line low while disabled or looped");
	bit_width_a: assert property ($rose(SERIAL_TX_LINE_O) |-> low_r % bit_w == 22'h00_0000)
		else $error("low run on tx line not whole bits");
	rts_sw_a: assert property (
		ctrl_calm_s ##0 !ctrl_r[uart_port_pkg::CTRL_RTS_AUTO]
		|-> REQUEST_TO_SEND_OUT_N_O == !ctrl_r[uart_port_pkg::CTRL_RTS_SW])
		else $error("request-to-send differs from software level");
	unmapped_read_a: assert property (take_w && !HWRITE_I && HADDR_I >= 32'h0000_0018 |=> HRDATA_O == 32'h0000_0000)
		else $error("unmapped read not zero");
	ctrl_read_a: assert property (rd_ctrl_s |=> (HRDATA_O & 32'hFFFF_FFF7) == 32'($past(ctrl_r) & 7'h77))
		else $error("control read back wrong");
	div_read_a: assert property (rd_div_s |=> HRDATA_O == 32'($past(div_r)))
		else $error("divider read back wrong");
endmodule : uart_port_monitor
bind uart_port uart_port_monitor #(.RXQ_DEPTH(RXQ_DEPTH)) i_mon (
	.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
	.HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
	.HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
	.SERIAL_RX_LINE_I(SERIAL_RX_LINE_I), .CLEAR_TO_SEND_IN_N_I(CLEAR_TO_SEND_IN_N_I),
	.SERIAL_TX_LINE_O(SERIAL_TX_LINE_O), .REQUEST_TO_SEND_OUT_N_O(REQUEST_TO_SEND_OUT_N_O)
);
`default_nettype wire

/* tb/uart_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_peer #(
	parameter int BIT_CYC = 32
) (
	input  wire logic clk_i,
	input  wire logic tx_line_i,
	output logic      rx_line_o,
	output logic      cts_n_o
);
	// line idles at mark, sending permitted
	initial begin
		rx_line_o = 1'b1;
		cts_n_o = 1'b0;
	end
	// one character toward the port
	task automatic send_byte(input logic [7:0] b, input logic stop);
		@(posedge clk_i);
		rx_line_o <= 1'b0;
		repeat (BIT_CYC) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			rx_line_o <= b[i];
			repeat (BIT_CYC) @(posedge clk_i);
		end
		rx_line_o <= stop;
		repeat (BIT_CYC) @(posedge clk_i);
		// a low stop bit is released to mark afterwards
		rx_line_o <= 1'b1;
		repeat (BIT_CYC / 2) @(posedge clk_i);
	endtask : send_byte
	// catch one character, sampled mid-bit; gives up after a long idle
	task automatic recv_byte(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (tx_line_i === 1'b1 && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		repeat (BIT_CYC / 2) @(posedge clk_i);
		ok = (tx_line_i === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk_i);
			b[i] = tx_line_i;
		end
		repeat (BIT_CYC) @(posedge clk_i);
		ok = ok && (tx_line_i === 1'b1);
	endtask : recv_byte
	// hold off or permit sending
	task automatic set_cts(input logic v);
		@(posedge clk_i);
		cts_n_o <= v;
	endtask : set_cts
endmodule : uart_peer
`default_nettype wire

/* tb/tb_uart_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_uart_port;
	logic        mclk   = 1'b0;
	logic        rst_n  = 1'b0;
	logic        hsel   = 1'b0;
	logic [31:0] haddr  = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize  = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic        hready;  // single slave feeds its own ready back
	logic        rx_line;
	logic        cts_n;
	logic        tx_line;
	logic        rts_n;
	logic [31:0] rd;      // last word read
	logic [7:0]  got;     // byte caught by the peer
	logic        ok;      // peer saw good framing
	int          num_errors = 0;
	int          checked = 0;
	int          cycles = 0;
	always #12.5 mclk = ~mclk;
	uart_port i_dut (
		.MCLK_I(mclk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
		.HREADYOUT_O(hready), .HRESP_O(), .SERIAL_RX_LINE_I(rx_line), .CLEAR_TO_SEND_IN_N_I(cts_n),
		.SERIAL_TX_LINE_O(tx_line), .REQUEST_TO_SEND_OUT_N_O(rts_n));
	// divider zero gives 32 clocks a bit
	uart_peer #(.BIT_CYC(32)) i_peer (.clk_i(mclk), .tx_line_i(tx_line), .rx_line_o(rx_line), .cts_n_o(cts_n));
	function automatic logic [31:0] ctl(input int b);
		return 32'h0000_0001 << b;
	endfunction : ctl
	// one single word transfer, held until ready is seen
	task automatic bus_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus_xfer
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		bus_xfer(1'b0, a, 32'h0000_0000);
		chk(n, e, rd);
	endtask : rchk
	task automatic tx_expect(input logic [7:0] e);
		i_peer.recv_byte(got, ok);
		chk("tx framing", 32'h0000_0001, 32'(ok));
		chk("tx byte", 32'(e), 32'(got));
	endtask : tx_expect
	// tx line must stay at mark for a whole frame time
	task automatic watch_high(input string n);
		int lows;
		lows = 0;
		repeat (400) begin
			@(posedge mclk);
			if (tx_line !== 1'b1) lows++;
		end
		chk(n, 32'h0000_0000, 32'(lows));
	endtask : watch_high
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// hang guard; all tests need about 3000 cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		// reset values, write-only and unmapped places
		rchk(uart_port_pkg::OFS_CTRL, 32'(uart_port_pkg::CTRL_RST), "ctrl");
		rchk(uart_port_pkg::OFS_DIV, 32'(uart_port_pkg::DIV_RST), "div");
		rchk(uart_port_pkg::OFS_RTSLVL, 32'(uart_port_pkg::RTSLVL_RST), "rts level");
		rchk(uart_port_pkg::OFS_STATUS, ctl(uart_port_pkg::ST_CLK_RUN) | ctl(uart_port_pkg::ST_CTS), "status");
		rchk(uart_port_pkg::OFS_TXDATA, 32'h0000_0000, "txdata");
		rchk(8'h18, 32'h0000_0000, "unmapped");
		chk("idle tx", 32'h0000_0001, 32'(tx_line));
		$display("test reset done");
		// back-to-back frames, refilled as soon as holding frees
		bus_xfer(1'b1, uart_port_pkg::OFS_DIV, 32'h0000_0000);
		bus_xfer(1'b1, uart_port_pkg::OFS_CTRL, ctl(uart_port_pkg::CTRL_TX_EN));
		bus_xfer(1'b1, uart_port_pkg::OFS_TXDATA, 32'h0000_00A5);
		fork
			tx_expect(8'hA5);
			begin
				do bus_xfer(1'b0, uart_port_pkg::OFS_STATUS, 32'h0000_0000);
				while (rd[uart_port_pkg::ST_HOLD_FULL] !== 1'b0);
				bus_xfer(1'b1, uart_port_pkg::OFS_TXDATA, 32'h0000_003C);
			end
		join
		tx_expect(8'h3C);
		$display("test transmit done");
		// peer withholds clear-to-send, then permits it
		i_peer.set_cts(1'b1);
		bus_xfer(1'b1, uart_port_pkg::OFS_CTRL, ctl(uart_port_pkg::CTRL_TX_EN) | ctl(uart_port_pkg::CTRL_CTS_EN));
		bus_xfer(1'b1, uart_port_pkg::OFS_TXDATA, 32'h0000_005A);
		watch_high("held by cts");
		i_peer.set_cts(1'b0);
		tx_expect(8'h5A);
		$display("test clear-to-send done");
		// loopback keeps the pin at mark yet receives internally
		bus_xfer(1'b1, uart_port_pkg::OFS_CTRL, 32'h0000_0007);
		bus_xfer(1'b1, uart_port_pkg::OFS_TXDATA, 32'h0000_0096);
		watch_high("loopback tx");
		rchk(uart_port_pkg::OFS_RXDATA, 32'h0000_0096, "loopback rx");
		$display("test loopback done");
		// receive with request-to-send following the queue level
		bus_xfer(1'b1, uart_port_pkg::OFS_RTSLVL, 32'h0000_0001);
		bus_xfer(1'b1, uart_port_pkg::OFS_CTRL, ctl(uart_port_pkg::CTRL_RX_EN) | ctl(uart_port_pkg::CTRL_RTS_AUTO));
		repeat (3) @(posedge mclk);
		chk("rts below level", 32'h0000_0000, 32'(rts_n));
		i_peer.send_byte(8'hC3, 1'b1);
		chk("rts at level", 32'h0000_0001, 32'(rts_n));
		rchk(uart_port_pkg::OFS_RXDATA, 32'h0000_00C3, "rx byte");
		repeat (3) @(posedge mclk);
		chk("rts after pop", 32'h0000_0000, 32'(rts_n));
		$display("test receive done");
		// power-down stops the serial clock, line activity wakes it
		bus_xfer(1'b1, uart_port_pkg::OFS_CTRL, ctl(uart_port_pkg::CTRL_PDOWN));
		for (int i = 0; i < 20 && rd[uart_port_pkg::ST_CLK_RUN] !== 1'b0; i++) begin
			bus_xfer(1'b0, uart_port_pkg::OFS_STATUS, 32'h0000_0000);
		end
		chk("clock stopped", 32'h0000_0000, 32'(rd[uart_port_pkg::ST_CLK_RUN]));
		chk("rts negated", 32'h0000_0001, 32'(rts_n));
		i_peer.send_byte(8'hF0, 1'b1);
		bus_xfer(1'b0, uart_port_pkg::OFS_STATUS, 32'h0000_0000);
		chk("clock woken", 32'h0000_0001, 32'(rd[uart_port_pkg::ST_CLK_RUN]));
		rchk(uart_port_pkg::OFS_CTRL, 32'h0000_0000, "power-down cleared");
		$display("test power-down done");
		// a low stop bit flags a framing error and queues nothing
		bus_xfer(1'b1, uart_port_pkg::OFS_CTRL, ctl(uart_port_pkg::CTRL_RX_EN));
		i_peer.send_byte(8'hFF, 1'b0);
		rchk(uart_port_pkg::OFS_STATUS, ctl(uart_port_pkg::ST_FRAME_ERR) | ctl(uart_port_pkg::ST_CLK_RUN)
			| ctl(uart_port_pkg::ST_CTS), "framing error");
		bus_xfer(1'b1, uart_port_pkg::OFS_STATUS, ctl(uart_port_pkg::ST_FRAME_ERR));
		rchk(uart_port_pkg::OFS_STATUS, ctl(uart_port_pkg::ST_CLK_RUN) | ctl(uart_port_pkg::ST_CTS),
			"framing cleared");
		$display("test framing error done");
		report_and_stop();
	end
endmodule : tb_uart_port
`default_nettype wire
